// *** common/lpm_pkg.sv ***
// Purpose: Shared constants and types for the low power mode controller
// Assumes: 20 MHz ref_clk, plain register port with 4-bit byte address
// Notes: Register offsets are word aligned
`default_nettype none
package lpm_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int GPIO_LINES = 16;
	localparam int CLK_PERIOD_NS = 50;
	//////////////////////////////////////////////////////////////////////
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] FLAG_OFS = 4'h8;
	//////////////////////////////////////////////////////////////////////
	localparam int CTRL_W = 5;
	localparam int CTRL_DS = 0;
	localparam int CTRL_DP = 1;
	localparam int CTRL_LP = 2;
	localparam int CTRL_VDEN = 3;
	localparam int CTRL_CLK_EXT = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	//////////////////////////////////////////////////////////////////////
	localparam int ST_MODE_LSB = 0;
	localparam int ST_MODE_W = 3;
	localparam int ST_VD_LVL = 3;
	localparam int ST_CLK_INT = 4;
	localparam int ST_LP_LATCHED = 5;
	localparam int FLAG_W = 2;
	localparam int FLAG_VD_EDGE = 0;
	localparam int FLAG_STBY_WAKE = 1;
	localparam logic [FLAG_W-1:0] FLAG_RST = 2'h0;
	localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
	//////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		LPM_RUN = 3'h0,
		LPM_SLEEP = 3'h1,
		LPM_STOP = 3'h3,
		LPM_STANDBY = 3'h2,
		LPM_WAKE_RST = 3'h6
	} lpm_state_e;
	typedef enum logic [1:0] {
		LPM_REG_NORMAL = 2'h0,
		LPM_REG_LOW = 2'h1,
		LPM_REG_OFF = 2'h2
	} lpm_reg_e;
endpackage
`default_nettype wire

// *** common/lpm_wake_if.sv ***
// Purpose: Wake source bundle between the mode controller and its detector
// Assumes: Single clock domain
// Notes: All detector outputs are registered
`timescale 1ns/1ps
`default_nettype none
interface lpm_wake_if;
	logic vd_en;
	logic vd_level;
	logic vd_edge;
	logic ext_wake;
	logic rst_req;
	modport ctl(output vd_en, input vd_level, input vd_edge, input ext_wake, input rst_req);
	modport det(input vd_en, output vd_level, output vd_edge, output ext_wake, output rst_req);
endinterface
`default_nettype wire

// *** rtl/lpm_wake.sv ***
// Purpose: Collects wake sources and watches the voltage detector
// Assumes: All inputs synchronous to ref_clk
// Notes: Outputs lag their sources by one cycle, except ext_wake from the comparator, which lags two
`timescale 1ns/1ps
`default_nettype none
module lpm_wake (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [lpm_pkg::GPIO_LINES-1:0] gpio_event_lines,
	input wire logic vd_compare,
	input wire logic rtc_alarm,
	input wire logic usb_wakeup,
	input wire logic wakeup_pin,
	input wire logic external_reset_pin_n,
	input wire logic independent_watchdog_timer_rst,
	lpm_wake_if.det wk
);
	logic pin_q;
	logic vd_armed;
	//////////////////////////////////////////////////////////////////////
	// Comparator ignored until software enables it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wk.vd_level <= 1'b0;
			vd_armed <= 1'b0;
			wk.vd_edge <= 1'b0;
		end else begin
			wk.vd_level <= wk.vd_en & vd_compare;
			vd_armed <= wk.vd_en;
			// Arming delay stops the enable itself looking like an edge
			wk.vd_edge <= wk.vd_en & vd_armed & (vd_compare != wk.vd_level);
		end
	end
	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_q <= 1'b0;
			wk.ext_wake <= 1'b0;
			wk.rst_req <= 1'b0;
		end else begin
			pin_q <= wakeup_pin;
			wk.ext_wake <= (|gpio_event_lines) | wk.vd_level | rtc_alarm | usb_wakeup
				| (wakeup_pin & ~pin_q) | ~external_reset_pin_n
				| independent_watchdog_timer_rst;
			wk.rst_req <= ~external_reset_pin_n | independent_watchdog_timer_rst;
		end
	end
endmodule // lpm_wake
`default_nettype wire

// *** rtl/lpm_ctrl.sv ***
// Purpose: Sleep, stop and standby sequencing with regulator and clock gating
// Assumes: Wait instruction inputs are one-cycle pulses from the core
// Notes: Registers are retained through stop; control cleared by any system reset, flags only by rst
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic supply_ok,
	input wire logic wait_instr,
	input wire logic wait_event_instr,
	input wire logic irq_pending,
	input wire logic wake_event,
	input wire logic [lpm_pkg::GPIO_LINES-1:0] gpio_event_lines,
	input wire logic vd_compare,
	input wire logic rtc_alarm,
	input wire logic usb_wakeup,
	input wire logic wakeup_pin,
	input wire logic external_reset_pin_n,
	input wire logic independent_watchdog_timer_rst,
	input wire logic [lpm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [lpm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [lpm_pkg::DATA_W-1:0] reg_rdata,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic pll_en,
	output logic internal_fast_osc_en,
	output logic external_fast_osc_en,
	output logic flash_low_power,
	output logic [1:0] regulator_mode,
	output logic core_supply_en,
	output logic sys_reset,
	output logic sysclk_internal,
	output logic vd_irq
);
	lpm_wake_if wk();
	lpm_pkg::lpm_state_e state;
	lpm_pkg::lpm_state_e next_state;
	logic [lpm_pkg::CTRL_W-1:0] ctrl;
	logic [lpm_pkg::FLAG_W-1:0] flags;
	logic lp_latched;
	logic sys_rst_req;
	logic wait_any;
	logic ctrl_wr;
	logic flag_wr;
	logic leave_low_power;

	function automatic logic hit(input logic [lpm_pkg::ADDR_W-1:0] ofs);
		hit = (reg_addr == ofs);
	endfunction

	//////////////////////////////////////////////////////////////////////
	lpm_wake u_wake (
		.ref_clk(ref_clk),
		.rst(rst),
		.gpio_event_lines(gpio_event_lines),
		.vd_compare(vd_compare),
		.rtc_alarm(rtc_alarm),
		.usb_wakeup(usb_wakeup),
		.wakeup_pin(wakeup_pin),
		.external_reset_pin_n(external_reset_pin_n),
		.independent_watchdog_timer_rst(independent_watchdog_timer_rst),
		.wk(wk)
	);

	assign wk.vd_en = ctrl[lpm_pkg::CTRL_VDEN];
	assign wait_any = wait_instr | wait_event_instr;
	assign ctrl_wr = reg_wr & hit(lpm_pkg::CTRL_OFS);
	assign flag_wr = reg_wr & hit(lpm_pkg::FLAG_OFS);
	// A standby wake goes through one reset cycle before running again
	assign sys_rst_req = ~supply_ok | wk.rst_req | (state == lpm_pkg::LPM_WAKE_RST);
	assign leave_low_power = (state != lpm_pkg::LPM_RUN) && (next_state == lpm_pkg::LPM_RUN);

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		case (state)
			lpm_pkg::LPM_RUN: begin
				if (wait_any) begin
					if (!ctrl[lpm_pkg::CTRL_DS]) begin
						next_state = lpm_pkg::LPM_SLEEP;
					end else if (ctrl[lpm_pkg::CTRL_DP]) begin
						next_state = lpm_pkg::LPM_STANDBY;
					end else begin
						next_state = lpm_pkg::LPM_STOP;
					end
				end
			end
			lpm_pkg::LPM_SLEEP: begin
				if (irq_pending | wake_event | wk.ext_wake) begin
					next_state = lpm_pkg::LPM_RUN;
				end
			end
			lpm_pkg::LPM_STOP: begin
				if (wk.ext_wake) begin
					next_state = lpm_pkg::LPM_RUN;
				end
			end
			lpm_pkg::LPM_STANDBY: begin
				if (wk.ext_wake) begin
					next_state = lpm_pkg::LPM_WAKE_RST;
				end
			end
			lpm_pkg::LPM_WAKE_RST: begin
				next_state = lpm_pkg::LPM_RUN;
			end
			default: begin
				next_state = lpm_pkg::LPM_RUN;
			end
		endcase
		if (sys_rst_req && state != lpm_pkg::LPM_STANDBY) begin
			next_state = lpm_pkg::LPM_RUN;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= lpm_pkg::LPM_RUN;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lp_latched <= 1'b0;
		end else if (state == lpm_pkg::LPM_RUN && wait_any) begin
			lp_latched <= ctrl[lpm_pkg::CTRL_LP];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Control and flag registers
	// No retention logic needed in stop: nothing here clears on entry
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl <= lpm_pkg::CTRL_RST;
		end else if (sys_rst_req) begin
			ctrl <= lpm_pkg::CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl <= reg_wdata[lpm_pkg::CTRL_W-1:0];
		end
	end

	// Set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flags <= lpm_pkg::FLAG_RST;
		end else begin
			if (flag_wr && reg_wdata[lpm_pkg::FLAG_VD_EDGE]) begin
				flags[lpm_pkg::FLAG_VD_EDGE] <= 1'b0;
			end
			if (flag_wr && reg_wdata[lpm_pkg::FLAG_STBY_WAKE]) begin
				flags[lpm_pkg::FLAG_STBY_WAKE] <= 1'b0;
			end
			if (wk.vd_edge) begin
				flags[lpm_pkg::FLAG_VD_EDGE] <= 1'b1;
			end
			if (state == lpm_pkg::LPM_WAKE_RST) begin
				flags[lpm_pkg::FLAG_STBY_WAKE] <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= lpm_pkg::RDATA_ZERO;
		end else begin
			reg_rdata <= lpm_pkg::RDATA_ZERO;
			if (reg_rd && hit(lpm_pkg::CTRL_OFS)) begin
				reg_rdata[lpm_pkg::CTRL_W-1:0] <= ctrl;
			end else if (reg_rd && hit(lpm_pkg::STATUS_OFS)) begin
				reg_rdata[lpm_pkg::ST_MODE_LSB +: lpm_pkg::ST_MODE_W] <= state;
				reg_rdata[lpm_pkg::ST_VD_LVL] <= wk.vd_level;
				reg_rdata[lpm_pkg::ST_CLK_INT] <= sysclk_internal;
				reg_rdata[lpm_pkg::ST_LP_LATCHED] <= lp_latched;
			end else if (reg_rd && hit(lpm_pkg::FLAG_OFS)) begin
				reg_rdata[lpm_pkg::FLAG_W-1:0] <= flags;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Gating outputs follow next_state so they change with the state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cpu_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			pll_en <= 1'b1;
			internal_fast_osc_en <= 1'b1;
			external_fast_osc_en <= 1'b1;
			flash_low_power <= 1'b0;
			regulator_mode <= lpm_pkg::LPM_REG_NORMAL;
			core_supply_en <= 1'b1;
		end else begin
			cpu_clk_en <= (next_state == lpm_pkg::LPM_RUN);
			periph_clk_en <= (next_state == lpm_pkg::LPM_RUN)
				|| (next_state == lpm_pkg::LPM_SLEEP);
			pll_en <= (next_state == lpm_pkg::LPM_RUN)
				|| (next_state == lpm_pkg::LPM_SLEEP);
			internal_fast_osc_en <= (next_state != lpm_pkg::LPM_STOP)
				&& (next_state != lpm_pkg::LPM_STANDBY);
			external_fast_osc_en <= (next_state == lpm_pkg::LPM_RUN)
				|| (next_state == lpm_pkg::LPM_SLEEP);
			flash_low_power <= (next_state == lpm_pkg::LPM_STOP)
				|| (next_state == lpm_pkg::LPM_STANDBY);
			core_supply_en <= (next_state != lpm_pkg::LPM_STANDBY);
			case (next_state)
				lpm_pkg::LPM_STOP: begin
					// Latch is still loading on the entry edge, so read the select bit there
					if (state == lpm_pkg::LPM_STOP) begin
						regulator_mode <= lp_latched ? lpm_pkg::LPM_REG_LOW
							: lpm_pkg::LPM_REG_NORMAL;
					end else begin
						regulator_mode <= ctrl[lpm_pkg::CTRL_LP] ? lpm_pkg::LPM_REG_LOW
							: lpm_pkg::LPM_REG_NORMAL;
					end
				end
				lpm_pkg::LPM_STANDBY: begin
					regulator_mode <= lpm_pkg::LPM_REG_OFF;
				end
				default: begin
					regulator_mode <= lpm_pkg::LPM_REG_NORMAL;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sys_reset <= 1'b1;
		end else begin
			sys_reset <= sys_rst_req;
		end
	end

	// Wake wins over a software clock selection in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sysclk_internal <= 1'b1;
		end else if (leave_low_power || sys_rst_req) begin
			sysclk_internal <= 1'b1;
		end else if (ctrl_wr) begin
			sysclk_internal <= ~reg_wdata[lpm_pkg::CTRL_CLK_EXT];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			vd_irq <= 1'b0;
		end else begin
			vd_irq <= wk.vd_edge;
		end
	end

	//////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_run_wait;
		state == lpm_pkg::LPM_RUN && wait_any && !sys_rst_req;
	endsequence
	sequence s_stby_wake;
		state == lpm_pkg::LPM_STANDBY && wk.ext_wake;
	endsequence

	a_sleep_entry: assert property (s_run_wait and !ctrl[lpm_pkg::CTRL_DS]
		|=> state == lpm_pkg::LPM_SLEEP && !cpu_clk_en)
		else $error("sleep not entered");
	a_sleep_gating: assert property (state == lpm_pkg::LPM_SLEEP
		|-> periph_clk_en && !cpu_clk_en && pll_en)
		else $error("sleep gating wrong");
	a_sleep_exit: assert property (state == lpm_pkg::LPM_SLEEP && irq_pending
		|=> state == lpm_pkg::LPM_RUN && cpu_clk_en)
		else $error("sleep did not end");
	a_stop_regulator: assert property (state == lpm_pkg::LPM_STOP
		|-> regulator_mode == (lp_latched ? lpm_pkg::LPM_REG_LOW : lpm_pkg::LPM_REG_NORMAL))
		else $error("stop regulator state wrong");
	a_stop_osc_off: assert property (state == lpm_pkg::LPM_STOP
		|-> !pll_en && !internal_fast_osc_en && !external_fast_osc_en)
		else $error("oscillator left on in stop");
	a_stop_flash_low: assert property (state == lpm_pkg::LPM_STOP |-> flash_low_power)
		else $error("flash not in low power");
	a_stop_ctrl_kept: assert property (state == lpm_pkg::LPM_STOP && !sys_rst_req
		&& !ctrl_wr |=> ctrl == $past(ctrl))
		else $error("control lost in stop");
	a_stop_exit: assert property (state == lpm_pkg::LPM_STOP && wk.ext_wake
		&& !sys_rst_req |=> state == lpm_pkg::LPM_RUN ##1 !sys_reset)
		else $error("stop did not resume");
	a_standby_supply: assert property (state == lpm_pkg::LPM_STANDBY
		|-> !core_supply_en && !pll_en && !internal_fast_osc_en)
		else $error("standby supply left on");
	a_standby_reset: assert property (s_stby_wake
		|=> state == lpm_pkg::LPM_WAKE_RST ##1 sys_reset && state == lpm_pkg::LPM_RUN)
		else $error("standby wake without reset");
	a_reset_regulator: assert property (sys_reset && state != lpm_pkg::LPM_STANDBY
		|-> regulator_mode == lpm_pkg::LPM_REG_NORMAL)
		else $error("regulator not normal in reset");
	a_standby_reg_off: assert property (state == lpm_pkg::LPM_STANDBY
		|-> regulator_mode == lpm_pkg::LPM_REG_OFF)
		else $error("regulator not off in standby");
	a_supply_hold: assert property (!supply_ok |=> sys_reset)
		else $error("low supply not held in reset");
	a_pin_reset: assert property (wk.rst_req |=> sys_reset)
		else $error("reset pin or watchdog not applied");
	a_vd_gated: assert property (!ctrl[lpm_pkg::CTRL_VDEN] |-> ##2 !vd_irq)
		else $error("detector irq while disabled");
	a_vd_irq_edge: assert property ($rose(wk.vd_level) && $past(wk.vd_en, 2)
		&& $past(wk.vd_en) && wk.vd_en |=> vd_irq)
		else $error("detector edge missed");
	a_vd_irq_fall: assert property ($fell(wk.vd_level) && $past(wk.vd_en, 2)
		&& $past(wk.vd_en) && wk.vd_en |=> vd_irq)
		else $error("detector falling edge missed");
	a_sleep_evt_exit: assert property (state == lpm_pkg::LPM_SLEEP && wake_event
		|=> state == lpm_pkg::LPM_RUN && cpu_clk_en)
		else $error("sleep did not end on event");
	a_wake_clock: assert property ($past(state) == lpm_pkg::LPM_STOP
		&& state == lpm_pkg::LPM_RUN |-> sysclk_internal)
		else $error("wake kept external clock");
	a_mode_sample: assert property (s_run_wait and ctrl[lpm_pkg::CTRL_DS]
		|=> state == ($past(ctrl[lpm_pkg::CTRL_DP]) ? lpm_pkg::LPM_STANDBY : lpm_pkg::LPM_STOP))
		else $error("wrong deep mode entered");
endmodule // lpm_ctrl
`default_nettype wire

// *** sim/lpm_core_model.sv ***
// Purpose: Core side model issuing wait pulses, interrupts and wake events
// Assumes: Signals change by non-blocking assignment just after a rising edge
// Notes: Interrupt and event stay low unless a scenario raises them
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
	input wire logic ref_clk,
	output logic wait_instr,
	output logic wait_event_instr,
	output logic irq_pending,
	output logic wake_event
);
	initial begin
		wait_instr = 1'b0;
		wait_event_instr = 1'b0;
		irq_pending = 1'b0;
		wake_event = 1'b0;
	end
	// Select bits are written by the caller before this one-cycle pulse
	task automatic exec_wait(input bit evt);
		@(posedge ref_clk);
		wait_instr <= !evt;
		wait_event_instr <= evt;
		@(posedge ref_clk);
		wait_instr <= 1'b0;
		wait_event_instr <= 1'b0;
	endtask
	task automatic wake_core(input bit evt, input bit v);
		@(posedge ref_clk);
		irq_pending <= v & !evt;
		wake_event <= v & evt;
	endtask
endmodule // lpm_core_model
`default_nettype wire

// *** sim/lpm_ctrl_test.sv ***
// Purpose: Self-checking bench for the low power mode controller
// Assumes: 20 MHz clock, core model on the wait and wake side
// Notes: Output enables compared as one packed snapshot against a model
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_test;
	logic ref_clk, rst, supply_ok, irq_pending, wake_event, wait_instr, wait_event_instr;
	logic vd_compare, rtc_alarm, usb_wakeup, wakeup_pin, external_reset_pin_n;
	logic independent_watchdog_timer_rst, reg_wr, reg_rd, lp;
	logic [15:0] gpio_event_lines;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic cpu_clk_en, periph_clk_en, pll_en, internal_fast_osc_en, external_fast_osc_en;
	logic flash_low_power, core_supply_en, sys_reset, sysclk_internal, vd_irq;
	logic [1:0] regulator_mode;
	wire logic [8:0] outs;
	int n_mismatch, check_count, c;
	assign outs = {cpu_clk_en, periph_clk_en, pll_en, internal_fast_osc_en,
		external_fast_osc_en, flash_low_power, regulator_mode, core_supply_en};
	lpm_core_model u_lpm_core_model (.ref_clk(ref_clk), .wait_instr(wait_instr),
		.wait_event_instr(wait_event_instr), .irq_pending(irq_pending),
		.wake_event(wake_event));
	lpm_ctrl u_lpm_ctrl (.ref_clk(ref_clk), .rst(rst), .supply_ok(supply_ok),
		.wait_instr(wait_instr), .wait_event_instr(wait_event_instr),
		.irq_pending(irq_pending), .wake_event(wake_event),
		.gpio_event_lines(gpio_event_lines), .vd_compare(vd_compare),
		.rtc_alarm(rtc_alarm), .usb_wakeup(usb_wakeup), .wakeup_pin(wakeup_pin),
		.external_reset_pin_n(external_reset_pin_n),
		.independent_watchdog_timer_rst(independent_watchdog_timer_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.pll_en(pll_en), .internal_fast_osc_en(internal_fast_osc_en),
		.external_fast_osc_en(external_fast_osc_en), .flash_low_power(flash_low_power),
		.regulator_mode(regulator_mode), .core_supply_en(core_supply_en),
		.sys_reset(sys_reset), .sysclk_internal(sysclk_internal), .vd_irq(vd_irq));
	//////////////////////////////////////////////////////////////////////
	// Snapshot bits: cpu, periph, pll, int osc, ext osc, flash lp, regulator, core supply
	function automatic logic [8:0] model(input int st, input logic l);
		case (st)
			lpm_pkg::LPM_SLEEP: return 9'h0f1;
			lpm_pkg::LPM_STOP: return {7'h02, l, 1'b1};
			lpm_pkg::LPM_STANDBY: return 9'h00c;
			default: return 9'h1f1;
		endcase
	endfunction
	function automatic logic sig(input int k);
		case (k)
			0: return pll_en;
			1: return sys_reset;
			default: return sysclk_internal;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, e, reg_rdata & m);
	endtask
	// Bounded wait; a hang here shows as one mismatch, not a stuck run
	task automatic wait_sig(input int k, input logic v, input string nm);
		for (int n = 0; n < 10; n++) begin
			@(posedge ref_clk);
			#1;
			if (sig(k) === v) break;
		end
		chk(nm, v, sig(k));
	endtask
	task automatic cnt_irq(output int cnt);
		cnt = 0;
		repeat (5) begin
			@(posedge ref_clk);
			#1;
			if (vd_irq === 1'b1) cnt++;
		end
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (4000) @(posedge ref_clk);
		n_mismatch++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		supply_ok = 1'b1;
		{vd_compare, rtc_alarm, usb_wakeup, wakeup_pin} = 4'h0;
		external_reset_pin_n = 1'b1;
		independent_watchdog_timer_rst = 1'b0;
		gpio_event_lines = 16'h0000;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		n_mismatch = 0;
		check_count = 0;
		void'($urandom(61432));
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		wait_sig(1, 1'b0, "sys_reset_release");
		chk("outs_reset", model(lpm_pkg::LPM_RUN, 1'b0), outs);
		rd(lpm_pkg::CTRL_OFS, 32'h1f, 32'h0, "ctrl_reset");
		rd(4'hc, 32'hffffffff, 32'h0, "unmapped");
		// Sleep through both wait flavours, clock moved off internal first
		for (int k = 0; k < 2; k++) begin
			wr(lpm_pkg::CTRL_OFS, 32'h10);
			wait_sig(3, 1'b0, "sysclk_external");
			u_lpm_core_model.exec_wait(k[0]);
			#1;
			chk("sleep_outs", model(lpm_pkg::LPM_SLEEP, 1'b0), outs);
			u_lpm_core_model.wake_core(k[0], 1'b1);
			@(posedge ref_clk);
			#1;
			chk("sleep_wake", model(lpm_pkg::LPM_RUN, 1'b0), outs);
			chk("sleep_sysclk", 1'b1, sysclk_internal);
			u_lpm_core_model.wake_core(k[0], 1'b0);
		end
		// Stop, once per wake source
		for (int s = 0; s < 7; s++) begin
			lp = 1'($urandom_range(1, 0));
			wr(lpm_pkg::CTRL_OFS, {27'h0, 2'h3, lp, 2'h1});
			@(posedge ref_clk);
			u_lpm_core_model.exec_wait(s[0]);
			#1;
			chk("stop_outs", model(lpm_pkg::LPM_STOP, lp), outs);
			rd(lpm_pkg::STATUS_OFS, 32'h27, {26'h0, lp, 5'h03}, "stop_status");
			@(posedge ref_clk);
			case (s)
				0: gpio_event_lines <= 16'h0001 << $urandom_range(15, 0);
				1: vd_compare <= 1'b1;
				2: rtc_alarm <= 1'b1;
				3: usb_wakeup <= 1'b1;
				4: wakeup_pin <= 1'b1;
				5: external_reset_pin_n <= 1'b0;
				default: independent_watchdog_timer_rst <= 1'b1;
			endcase
			wait_sig(0, 1'b1, "stop_wake");
			if (s < 5) begin
				chk("stop_wake_outs", model(lpm_pkg::LPM_RUN, 1'b0), outs);
				chk("stop_sysclk", 1'b1, sysclk_internal);
				rd(lpm_pkg::CTRL_OFS, 32'h1f, {27'h0, 2'h3, lp, 2'h1}, "ctrl_kept");
			end
			@(posedge ref_clk);
			{gpio_event_lines, vd_compare, rtc_alarm, usb_wakeup, wakeup_pin} <= '0;
			external_reset_pin_n <= 1'b1;
			independent_watchdog_timer_rst <= 1'b0;
			wait_sig(1, 1'b0, "stop_reset_end");
		end
		// Standby and the reset that follows its wake
		wr(lpm_pkg::CTRL_OFS, 32'h3);
		u_lpm_core_model.exec_wait(1'b0);
		#1;
		chk("stby_outs", model(lpm_pkg::LPM_STANDBY, 1'b0), outs);
		@(posedge ref_clk);
		gpio_event_lines <= 16'h8000;
		wait_sig(1, 1'b1, "stby_reset");
		@(posedge ref_clk);
		gpio_event_lines <= 16'h0000;
		wait_sig(1, 1'b0, "stby_reset_end");
		chk("stby_after", model(lpm_pkg::LPM_RUN, 1'b0), outs);
		rd(lpm_pkg::CTRL_OFS, 32'h1f, 32'h0, "ctrl_cleared");
		rd(lpm_pkg::FLAG_OFS, 32'h2, 32'h2, "stby_flag");
		wr(lpm_pkg::FLAG_OFS, 32'h3);
		rd(lpm_pkg::FLAG_OFS, 32'h3, 32'h0, "flag_clear");
		// Supply below threshold
		@(posedge ref_clk);
		supply_ok <= 1'b0;
		wait_sig(1, 1'b1, "supply_low");
		repeat (20) @(posedge ref_clk);
		#1;
		chk("supply_hold", 1'b1, sys_reset);
		@(posedge ref_clk);
		supply_ok <= 1'b1;
		wait_sig(1, 1'b0, "supply_back");
		chk("supply_outs", model(lpm_pkg::LPM_RUN, 1'b0), outs);
		// Detector silent until enabled, then both crossings
		@(posedge ref_clk);
		vd_compare <= 1'b1;
		cnt_irq(c);
		chk("vd_disabled", 32'h0, c);
		wr(lpm_pkg::CTRL_OFS, 32'h8);
		repeat (2) @(posedge ref_clk);
		for (int e = 0; e < 2; e++) begin
			@(posedge ref_clk);
			vd_compare <= ~vd_compare;
			cnt_irq(c);
			chk("vd_edge", 32'h1, c);
		end
		rd(lpm_pkg::STATUS_OFS, 32'h8, 32'h8, "vd_level");
		rd(lpm_pkg::FLAG_OFS, 32'h1, 32'h1, "vd_flag");
		summarize();
	end
endmodule // lpm_ctrl_test
`default_nettype wire
